// ==== emt_pkg.sv ====
// Constants shared by the external bus timing controller.
// Assumes a single 50 MHz system clock and an AXI4-Lite register bus.
`default_nettype none
package emt_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_TIMING = 5'h00;
    localparam logic [4:0] OFS_CONFIG = 5'h04;
    localparam logic [4:0] OFS_PAGE = 5'h08;
    localparam logic [4:0] OFS_CMD = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    // Timing register fields and reset value (all maximum delays)
    localparam int SETUP_LSB = 6;
    localparam int WIDTH_LSB = 2;
    localparam int HOLD_LSB = 0;
    localparam logic [7:0] TIMING_RST = 8'hff;
    // Config register fields: code [4:2], latch width [1:0]
    localparam int CODE_LSB = 2;
    localparam int CODE_MSB = 4;
    localparam int ALEW_LSB = 0;
    localparam logic [4:0] CONFIG_RST = 5'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    // Codes with bank select from the page register
    localparam logic [2:0] CODE_NMUX_BANK = 3'h6;
    localparam logic [2:0] CODE_MUX_BANK = 3'h2;
    // Command register fields
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_WDATA_LSB = 16;
    localparam int CMD_WRITE_BIT = 24;
    localparam int CMD_WIDE_BIT = 25;
    // Fixed framing: two lead and two tail cycles give the four extra
    localparam logic [4:0] LEAD_CYC = 5'h02;
    localparam logic [4:0] TAIL_CYC = 5'h02;
    localparam logic [4:0] ALE_LOW_CYC = 5'h01;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Transfer sequence, Gray coded along the path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEAD = 3'h1,
        ST_ALEH = 3'h3,
        ST_ALEL = 3'h2,
        ST_SETUP = 3'h6,
        ST_STRB = 3'h7,
        ST_HOLD = 3'h5,
        ST_TAIL = 3'h4
    } emt_state_e;
endpackage
`default_nettype wire

// ==== emt_cnt.sv ====
// Phase length down-counter for the external bus sequencer.
// Assumes load pulses arrive on the same clock; last is high on the
// final cycle of a loaded phase.
`timescale 1ns/1ns
`default_nettype none
module emt_cnt #(
    parameter int W = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic last
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    initial
    begin
        if (W < 5)
            $error("emt_cnt: W must hold 16 cycles");
    end

    // Load wins; otherwise count down and stop at zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = load_val;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign last = (cnt_r == '0);
endmodule
`default_nettype wire

// ==== emt_top.sv ====
// External parallel memory bus controller with AXI4-Lite registers.
// Assumes an asynchronous memory on the pins and one 50 MHz clock.
// Function
// - Strobe lasts pulse width field plus one
// - Codes 101/110/111: wide moves non-multiplexed
// - Code 110 narrow moves: page drives upper
// - Codes 001/010/011: wide moves multiplexed
// - Codes 001/011 narrow moves: upper byte undriven
// - Transfer is four cycles beyond programmed phases
// - Multiplexed adds at least two latch cycles
// - Timing fields reset to maximum delays
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module emt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] addr_hi_o,
    output logic addr_hi_oe,
    output logic [7:0] addr_lo_o,
    output logic addr_lo_oe,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe,
    output logic rd_n,
    output logic wr_n,
    output logic ale
);
    // Register file and bus slave state
    logic [7:0] timing_r, timing_nxt;
    logic [4:0] config_r, config_nxt;
    logic [7:0] page_r, page_nxt;
    logic [25:0] cmd_r, cmd_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [4:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic start;
    // Sequencer state and pins
    emt_pkg::emt_state_e st_r, st_nxt;
    logic [7:0] tm_r, tm_nxt;
    logic [2:0] code_r, code_nxt;
    logic [1:0] alew_r, alew_nxt;
    logic load;
    logic [4:0] load_val;
    logic last;
    logic [7:0] hi_nxt, lo_nxt, do_nxt;
    logic hi_oe_nxt, lo_oe_nxt, do_oe_nxt, rd_n_nxt, wr_n_nxt, ale_nxt;
    logic [7:0] sync1_r, sync2_r;

    // Merge byte lanes of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        return res;
    endfunction

    // Bus slave: address and data taken in either order, one at a time
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rd_r;

    always_comb
    begin
        logic [31:0] m;
        logic [4:0] a;
        logic [31:0] d;
        logic [3:0] s;
        m = '0;
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        timing_nxt = timing_r;
        config_nxt = config_r;
        page_nxt = page_r;
        cmd_nxt = cmd_r;
        start = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        a = aw_full_nxt ? aw_addr_nxt : aw_addr_r;
        d = w_data_nxt;
        s = w_strb_nxt;
        if (aw_full_nxt && w_full_nxt && !bvalid_r)
        begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = emt_pkg::RESP_OKAY;
            unique case ({a[4:2], 2'b00})
                emt_pkg::OFS_TIMING:
                begin
                    m = merge({24'h000000, timing_r}, d, s);
                    timing_nxt = m[7:0];
                end
                emt_pkg::OFS_CONFIG:
                begin
                    m = merge({27'h0000000, config_r}, d, s);
                    config_nxt = m[4:0];
                end
                emt_pkg::OFS_PAGE:
                begin
                    m = merge({24'h000000, page_r}, d, s);
                    page_nxt = m[7:0];
                end
                emt_pkg::OFS_CMD:
                begin
                    // A busy sequencer refuses a new move
                    if (st_r != emt_pkg::ST_IDLE)
                        bresp_nxt = emt_pkg::RESP_SLVERR;
                    else
                    begin
                        m = merge({6'h00, cmd_r}, d, s);
                        cmd_nxt = m[25:0];
                        start = 1'b1;
                    end
                end
                default:
                    bresp_nxt = emt_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Read side answers one cycle after the address is taken
    always_comb
    begin
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rd_nxt = rd_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = emt_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[4:2], 2'b00})
                emt_pkg::OFS_TIMING: rd_nxt = {24'h000000, timing_r};
                emt_pkg::OFS_CONFIG: rd_nxt = {27'h0000000, config_r};
                emt_pkg::OFS_PAGE: rd_nxt = {24'h000000, page_r};
                emt_pkg::OFS_CMD: rd_nxt = {6'h00, cmd_r};
                emt_pkg::OFS_STATUS:
                    rd_nxt = {16'h0000, rdata_r, 7'h00,
                              st_r != emt_pkg::ST_IDLE};
                default:
                begin
                    rd_nxt = '0;
                    rresp_nxt = emt_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timing_r <= emt_pkg::TIMING_RST;
            config_r <= emt_pkg::CONFIG_RST;
            page_r <= emt_pkg::PAGE_RST;
            cmd_r <= '0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= emt_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= emt_pkg::RESP_OKAY;
            rd_r <= '0;
        end
        else
        begin
            timing_r <= timing_nxt;
            config_r <= config_nxt;
            page_r <= page_nxt;
            cmd_r <= cmd_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rd_r <= rd_nxt;
        end
    end

    emt_cnt #(
        .W(5)
    ) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(load),
        .load_val(load_val),
        .last(last)
    );

    // Sequencer: timing and config are snapshotted at start; the page register is read
    // live, so a page write in mid-move changes the upper byte of a bank move
    always_comb
    begin
        logic [1:0] su;
        logic [3:0] wd;
        logic [1:0] ho;
        logic mux;
        logic bank;
        logic [25:0] c;
        // The command word lands with start, so the first pin cycle
        // must see the new word, not the previous one
        c = start ? cmd_nxt : cmd_r;
        st_nxt = st_r;
        tm_nxt = tm_r;
        code_nxt = code_r;
        alew_nxt = alew_r;
        load = 1'b0;
        load_val = '0;
        rdata_nxt = rdata_r;
        su = tm_r[emt_pkg::SETUP_LSB +: 2];
        wd = tm_r[emt_pkg::WIDTH_LSB +: 4];
        ho = tm_r[emt_pkg::HOLD_LSB +: 2];
        mux = !code_r[2];
        unique case (st_r)
            emt_pkg::ST_IDLE:
                if (start)
                begin
                    tm_nxt = timing_r;
                    code_nxt = config_r[emt_pkg::CODE_MSB:emt_pkg::CODE_LSB];
                    alew_nxt = config_r[emt_pkg::ALEW_LSB +: 2];
                    st_nxt = emt_pkg::ST_LEAD;
                    load = 1'b1;
                    load_val = emt_pkg::LEAD_CYC - 5'h01;
                end
            emt_pkg::ST_LEAD:
                if (last)
                begin
                    load = 1'b1;
                    if (mux)
                    begin
                        st_nxt = emt_pkg::ST_ALEH;
                        load_val = {3'h0, alew_r};
                    end
                    else if (su != 2'h0)
                    begin
                        st_nxt = emt_pkg::ST_SETUP;
                        load_val = {3'h0, su - 2'h1};
                    end
                    else
                    begin
                        st_nxt = emt_pkg::ST_STRB;
                        load_val = {1'b0, wd};
                    end
                end
            emt_pkg::ST_ALEH:
                if (last)
                begin
                    st_nxt = emt_pkg::ST_ALEL;
                    load = 1'b1;
                    load_val = emt_pkg::ALE_LOW_CYC - 5'h01;
                end
            emt_pkg::ST_ALEL, emt_pkg::ST_SETUP:
                if (last)
                begin
                    load = 1'b1;
                    if (st_r == emt_pkg::ST_ALEL && su != 2'h0)
                    begin
                        st_nxt = emt_pkg::ST_SETUP;
                        load_val = {3'h0, su - 2'h1};
                    end
                    else
                    begin
                        st_nxt = emt_pkg::ST_STRB;
                        load_val = {1'b0, wd};
                    end
                end
            emt_pkg::ST_STRB:
                if (last)
                begin
                    load = 1'b1;
                    // Sampled at strobe end, after the two-flop delay
                    if (!c[emt_pkg::CMD_WRITE_BIT])
                        rdata_nxt = sync2_r;
                    if (ho != 2'h0)
                    begin
                        st_nxt = emt_pkg::ST_HOLD;
                        load_val = {3'h0, ho - 2'h1};
                    end
                    else
                    begin
                        st_nxt = emt_pkg::ST_TAIL;
                        load_val = emt_pkg::TAIL_CYC - 5'h01;
                    end
                end
            emt_pkg::ST_HOLD:
                if (last)
                begin
                    st_nxt = emt_pkg::ST_TAIL;
                    load = 1'b1;
                    load_val = emt_pkg::TAIL_CYC - 5'h01;
                end
            emt_pkg::ST_TAIL:
                if (last)
                    st_nxt = emt_pkg::ST_IDLE;
            default:
                st_nxt = emt_pkg::ST_IDLE;
        endcase

        // Pin values for the next state, registered below
        bank = (code_nxt == emt_pkg::CODE_NMUX_BANK) ||
               (code_nxt == emt_pkg::CODE_MUX_BANK);
        hi_nxt = c[emt_pkg::CMD_ADDR_LSB + 8 +: 8];
        hi_oe_nxt = 1'b0;
        lo_nxt = c[emt_pkg::CMD_ADDR_LSB +: 8];
        lo_oe_nxt = 1'b0;
        do_nxt = c[emt_pkg::CMD_WDATA_LSB +: 8];
        do_oe_nxt = 1'b0;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        ale_nxt = (st_nxt == emt_pkg::ST_ALEH);
        if (st_nxt != emt_pkg::ST_IDLE)
        begin
            if (c[emt_pkg::CMD_WIDE_BIT])
                hi_oe_nxt = 1'b1;
            else if (bank)
            begin
                hi_nxt = page_r;
                hi_oe_nxt = 1'b1;
            end
            // Narrow moves without bank select leave the upper byte
            // to the port latches
            if (code_nxt[2])
                lo_oe_nxt = 1'b1;
            else if (st_nxt == emt_pkg::ST_LEAD ||
                     st_nxt == emt_pkg::ST_ALEH ||
                     st_nxt == emt_pkg::ST_ALEL)
            begin
                do_nxt = c[emt_pkg::CMD_ADDR_LSB +: 8];
                do_oe_nxt = 1'b1;
            end
            if (c[emt_pkg::CMD_WRITE_BIT] &&
                (st_nxt == emt_pkg::ST_SETUP ||
                 st_nxt == emt_pkg::ST_STRB ||
                 st_nxt == emt_pkg::ST_HOLD))
                do_oe_nxt = 1'b1;
            if (st_nxt == emt_pkg::ST_STRB)
            begin
                wr_n_nxt = !c[emt_pkg::CMD_WRITE_BIT];
                rd_n_nxt = c[emt_pkg::CMD_WRITE_BIT];
            end
        end
    end

    // Sequencer, pin registers and read data synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= emt_pkg::ST_IDLE;
            tm_r <= emt_pkg::TIMING_RST;
            code_r <= '0;
            alew_r <= '0;
            rdata_r <= '0;
            addr_hi_o <= '0;
            addr_hi_oe <= 1'b0;
            addr_lo_o <= '0;
            addr_lo_oe <= 1'b0;
            data_o <= '0;
            data_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ale <= 1'b0;
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            tm_r <= tm_nxt;
            code_r <= code_nxt;
            alew_r <= alew_nxt;
            rdata_r <= rdata_nxt;
            addr_hi_o <= hi_nxt;
            addr_hi_oe <= hi_oe_nxt;
            addr_lo_o <= lo_nxt;
            addr_lo_oe <= lo_oe_nxt;
            data_o <= do_nxt;
            data_oe <= do_oe_nxt;
            rd_n <= rd_n_nxt;
            wr_n <= wr_n_nxt;
            ale <= ale_nxt;
            sync1_r <= data_i;
            sync2_r <= sync1_r;
        end
    end
endmodule
`default_nettype wire

// ==== emt_mem.sv ====
// Byte memory model on the external bus pins.
// Assumes registered pins and the same clock.
`timescale 1ns/1ns
`default_nettype none
module emt_mem (
    input wire logic aclk,
    input wire logic [7:0] addr_lo_o,
    input wire logic addr_lo_oe,
    input wire logic [7:0] data_o,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale,
    input wire logic [1:0] lag,
    output logic [7:0] data_i
);
    logic [7:0] mem [256];
    logic [7:0] lat_r;
    logic [7:0] last_r = 8'h00;
    logic [1:0] rcnt_r = 2'h0;
    logic [7:0] a;
    // Low address from own pins, else latched from the shared lane
    assign a = addr_lo_oe ? addr_lo_o : lat_r;
    // Latch on ale, store under write strobe, age the read strobe
    always_ff @(posedge aclk)
    begin
        if (ale)
            lat_r <= data_o;
        if (!wr_n)
            mem[a] <= data_o;
        rcnt_r <= rd_n ? 2'h0 : (rcnt_r == 2'h3 ? rcnt_r : rcnt_r + 2'h1);
        last_r <= data_i;
    end
    // Slow parts show junk for lag cycles; an idle lane toggles
    assign data_i = (!rd_n && rcnt_r >= lag) ? mem[a] : ~last_r;
endmodule
`default_nettype wire

// ==== emt_top_sva.sv ====
// Checker for the bus controller pins and write response.
// Assumes full-word register writes.
`timescale 1ns/1ns
`default_nettype none
module emt_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] addr_hi_o,
    input wire logic addr_hi_oe,
    input wire logic [7:0] addr_lo_o,
    input wire logic addr_lo_oe,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale
);
    logic [4:0] aw_q, cfg_q, s_n;
    logic [31:0] w_q, cmd_q, cmd_v;
    logic [7:0] tim_q, pg_q;
    logic [2:0] a_n;
    logic [5:0] o_n, tot;
    // Register copies and pin phase run lengths
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            w_q <= s_axi_wdata;
        if (!aresetn)
            {tim_q, cfg_q, pg_q} <= {8'hff, 5'h00, 8'h00};
        else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0)
            case (aw_q)
                emt_pkg::OFS_TIMING: tim_q <= w_q[7:0];
                emt_pkg::OFS_CONFIG: cfg_q <= w_q[4:0];
                emt_pkg::OFS_PAGE: pg_q <= w_q[7:0];
                emt_pkg::OFS_CMD: cmd_q <= w_q;
                default: ;
            endcase
        s_n <= (!rd_n || !wr_n) ? s_n + 5'h01 : 5'h00;
        a_n <= ale ? a_n + 3'h1 : 3'h0;
        o_n <= (addr_hi_oe || addr_lo_oe) ? o_n + 6'h01 : 6'h00;
    end
    // A command drives the pins from its response cycle on
    assign cmd_v = (s_axi_bvalid && s_axi_bresp == 2'h0
        && aw_q == emt_pkg::OFS_CMD) ? w_q : cmd_q;
    // Move length: four fixed cycles plus phases
    assign tot = 6'h05 + tim_q[7:6] + tim_q[5:2] + tim_q[1:0]
        + (cfg_q[4] ? 6'h00 : cfg_q[1:0] + 6'h02);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_idle_a: assert property ($rose(aresetn) |-> rd_n && wr_n && !ale
        && !data_oe && !addr_hi_oe && !addr_lo_oe) else $error("not idle");
    strobe_width_a: assert property ($rose(rd_n && wr_n) |->
        s_n == tim_q[5:2] + 5'h01) else $error("strobe width");
    move_len_a: assert property ($fell(addr_hi_oe || addr_lo_oe) |->
        o_n == tot) else $error("move length");
    latch_width_a: assert property ($fell(ale) |->
        a_n == cfg_q[1:0] + 3'h1) else $error("latch width");
    latch_lane_a: assert property (ale |-> data_oe && !cfg_q[4]
        && data_o == cmd_v[7:0]) else $error("latch lane");
    low_pins_a: assert property (addr_lo_oe |-> cfg_q[4]
        && addr_lo_o == cmd_v[7:0]) else $error("low address");
    upper_byte_a: assert property (addr_hi_oe |-> addr_hi_o ==
        (cmd_v[25] ? cmd_v[15:8] : pg_q)) else $error("upper byte");
    upper_drive_a: assert property ((!rd_n || !wr_n) && (cmd_v[25]
        || cfg_q[4:2] == 3'h6) |-> addr_hi_oe) else $error("no upper");
    no_bank_a: assert property (!cmd_v[25] && !cfg_q[4] && cfg_q[2]
        |-> !addr_hi_oe) else $error("upper driven");
    write_data_a: assert property (!wr_n |-> data_oe
        && data_o == cmd_v[23:16]) else $error("write data");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
endmodule
bind emt_top emt_top_sva u_sva (.*);
`default_nettype wire

// ==== ext_mem_bus_timing_bench.sv ====
// Self-checking bench for the bus controller.
// Assumes the memory model on the pins, checker bound in.
`timescale 1ns/1ns
`default_nettype none
module ext_mem_bus_timing_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, addr_hi_oe, addr_lo_oe, data_oe, rd_n, wr_n, ale;
    logic [1:0] s_axi_bresp, s_axi_rresp, lag = 2'h0;
    logic [31:0] s_axi_rdata;
    logic [7:0] addr_hi_o, addr_lo_o, data_i, data_o, hi_v;
    int num_errors = 0;
    int tests_run = 0;
    int n_strb = 0, n_oe = 0, n_ale = 0, n_hi = 0;
    emt_top u_dut (.*);
    emt_mem u_mem (.*);
    // 50 MHz clock
    always #10 aclk = ~aclk;
    // Running pin counts, compared across each move
    always @(posedge aclk)
    begin
        n_strb += (!rd_n || !wr_n);
        n_oe += (addr_hi_oe || addr_lo_oe);
        n_ale += ale;
        n_hi += addr_hi_oe;
        if (addr_hi_oe)
            hi_v = addr_hi_o;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 40)
        begin
            num_errors++;
            $display("wrong value at %0t: no answer", $time);
            results();
        end
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 40);
        tmo(n);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 40);
        tmo(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_idle();
        logic [31:0] st;
        logic [1:0] r;
        int n = 0;
        do
        begin
            axi_rd(emt_pkg::OFS_STATUS, st, r);
            n++;
        end
        while (st[0] && n < 40);
        tmo(n);
    endtask
    // One move, judged at the pins
    task automatic move(input logic [31:0] cmd, input logic [7:0] t,
        input logic [4:0] c);
        int s0, o0, a0, h0, tot;
        logic hi;
        logic [1:0] r;
        axi_wr(emt_pkg::OFS_CONFIG, {27'h0, c}, r);
        axi_wr(emt_pkg::OFS_TIMING, {24'h0, t}, r);
        s0 = n_strb;
        o0 = n_oe;
        a0 = n_ale;
        h0 = n_hi;
        axi_wr(emt_pkg::OFS_CMD, cmd, r);
        check(r, emt_pkg::RESP_OKAY);
        wait_idle();
        tot = 5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : c[1:0] + 2);
        hi = cmd[25] || c[4:2] == 3'h6 || c[4:2] == 3'h2;
        check(n_strb - s0, t[5:2] + 1);
        check(n_ale - a0, c[4] ? 0 : c[1:0] + 1);
        check(n_oe - o0, (hi || c[4]) ? tot : 0);
        check(n_hi - h0 != 0, hi);
        if (hi)
            check(hi_v, cmd[25] ? cmd[15:8] : 8'hc3);
    endtask
    // Reset values, read-back, unmapped place
    task automatic s_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(emt_pkg::OFS_TIMING, d, r);
        check(d, 32'h000000ff);
        axi_rd(emt_pkg::OFS_CONFIG, d, r);
        check(d, 32'h0);
        axi_rd(5'h14, d, r);
        check(r, emt_pkg::RESP_SLVERR);
        axi_wr(5'h18, 32'h1, r);
        check(r, emt_pkg::RESP_SLVERR);
        axi_wr(emt_pkg::OFS_PAGE, 32'hc3, r);
        axi_wr(emt_pkg::OFS_TIMING, 32'h5a, r);
        axi_rd(emt_pkg::OFS_TIMING, d, r);
        check(d, 32'h5a);
    endtask
    // Codes 001 to 111, narrow and wide
    task automatic s_codes();
        logic [7:0] t, d;
        logic [15:0] a;
        logic [4:0] c;
        logic [31:0] st;
        logic [1:0] r;
        for (int i = 1; i < 8; i++)
            for (int w = 0; w < 2; w++)
            begin
                t = (i == 1 || i == 5) ? 8'h00 : 8'(i * 8'h25);
                c = {3'(i), 2'(i - 1)};
                a = 16'(i * 16'h1111 + w * 16'h0010);
                d = 8'(i * 8'h13 + w);
                lag <= {1'b0, 1'(i)};
                move({6'h0, 1'(w), 1'b1, d, a}, t, c);
                move({6'h0, 1'(w), 1'b0, 8'h00, a}, t | 8'h20, c);
                axi_rd(emt_pkg::OFS_STATUS, st, r);
                check(st[15:8], d);
            end
    endtask
    // A command while busy is refused
    task automatic s_busy();
        int s0;
        logic [1:0] r;
        axi_wr(emt_pkg::OFS_TIMING, 32'hff, r);
        s0 = n_strb;
        axi_wr(emt_pkg::OFS_CMD, 32'h01a500f0, r);
        axi_wr(emt_pkg::OFS_CMD, 32'h015a00f1, r);
        check(r, emt_pkg::RESP_SLVERR);
        wait_idle();
        check(n_strb - s0, 16);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // Main sequence, reset again mid-run
    initial
    begin
        do_reset();
        s_regs();
        s_codes();
        s_busy();
        do_reset();
        s_regs();
        results();
    end
endmodule
`default_nettype wire
